/* dcdc_params.svh */
// register map, field positions, reset values and timing constants of the converter control
`ifndef DCDC_PARAMS_SVH
`define DCDC_PARAMS_SVH
`define CTRL_ADDR 32'h5000_0080
`define STAT_ADDR 32'h5000_0084
`define CTRL_RESET 16'h84a2
`define CEIL_HI 15
`define CEIL_LO 12
`define FLOOR_HI 11
`define FLOOR_LO 8
`define CLRCNT_HI 7
`define CLRCNT_LO 6
`define TMO_HI 5
`define TMO_LO 3
`define DIV_HI 2
`define DIV_LO 1
`define ENABLE_BIT 0
`define CEIL_RESET 4'h8
`define FLOOR_RESET 4'h4
`define STAT_GOOD_BIT 0
`define STAT_LIMIT_HI 7
`define STAT_LIMIT_LO 4
`define STAT_STATE_HI 10
`define STAT_STATE_LO 8
`define STAT_NOK_HI 15
`define STAT_NOK_LO 12
`define CLK_PERIOD_NS 20
`define TMO_STEP_NS 250
`define DIV_BASE_MASK 5'h03
`endif

/* dcdc_pkg.sv */
// types shared by the converter control files
`default_nettype none
package dcdc_pkg;
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    CHARGE = 3'b010,
    DISCHARGE = 3'b100
  } phase_t;
  typedef logic [3:0] limit_t;
endpackage
`default_nettype wire

/* pin_sync3.sv */
// three-stage synchroniser with agreement filter for the analogue comparator inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] rawIn,
  output logic [2:0] cleanOut
);
  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] stage3;
  logic [2:0] next_cleanOut;

  // a change counts only once the second and third stages agree
  always_comb begin
    next_cleanOut = cleanOut;
    for (int i = 0; i < 3; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_cleanOut[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 3'h0;
      stage2 <= 3'h0;
      stage3 <= 3'h0;
      cleanOut <= 3'h0;
    end else begin
      stage1 <= rawIn;
      stage2 <= stage1;
      stage3 <= stage2;
      cleanOut <= next_cleanOut;
    end
  end
endmodule // pin_sync3
`default_nettype wire

/* dcdc_hw_controller.sv */
// buck/boost converter control: apb register, switching phases, peak limit and output-good
// Operation
// - a 4-bit peak-current ceiling code n means 6 mA times (n+1) and resets to code 8.
// - a 4-bit peak-current floor code with the same steps resets to code 4.
// - while enabled, output-good clears only after 2, 4, 8 or 15 consecutive not-ok events, code reset 2 (8 events).
// - a switch on longer than the 3-bit timeout (0.25 us steps, 0 off) ends its phase.
// - while idle the output is sampled at the clock divided by 4, 8, 16 or 32, reset 8.
// - enable at 0 keeps the converter off, at 1 puts it under hardware control.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dcdc_params.svh"
module dcdc_hw_controller (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic outputLowRaw,
  input wire logic peakReachedRaw,
  input wire logic zeroCurrentRaw,
  output logic chargeSwitch,
  output logic dischargeSwitch,
  output dcdc_pkg::limit_t limitCode,
  output logic outputGood
);
  import dcdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] timeoutCycles(input logic [2:0] code);
    timeoutCycles = 7'((32'(code) * `TMO_STEP_NS) / `CLK_PERIOD_NS);
  endfunction

  function automatic logic [3:0] clearThreshold(input logic [1:0] code);
    case (code)
      2'h0: clearThreshold = 4'h2;
      2'h1: clearThreshold = 4'h4;
      2'h2: clearThreshold = 4'h8;
      default: clearThreshold = 4'hf;
    endcase
  endfunction

  function automatic limit_t clampLimit(input limit_t v, input limit_t lo, input limit_t hi);
    limit_t t;
    t = (v < lo) ? lo : v;
    clampLimit = (t > hi) ? hi : t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [2:0] cleanIn;
  logic outputLow;
  logic peakReached;
  logic zeroCurrent;

  pin_sync3 u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .rawIn({zeroCurrentRaw, peakReachedRaw, outputLowRaw}),
    .cleanOut(cleanIn)
  );
  assign outputLow = cleanIn[0];
  assign peakReached = cleanIn[1];
  assign zeroCurrent = cleanIn[2];

  ////////////////////////////////////////////////////////////////////////////////
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic ctrlHit;
  logic statHit;
  logic access;
  logic [31:0] statWord;
  phase_t phase;
  logic [3:0] nokCount;

  assign ctrlHit = (paddr == `CTRL_ADDR);
  assign statHit = (paddr == `STAT_ADDR);
  // one wait state keeps prdata and pready straight from flops
  assign access = psel && penable && !pready;

  always_comb begin
    statWord = 32'h0;
    statWord[`STAT_GOOD_BIT] = outputGood;
    statWord[`STAT_LIMIT_HI:`STAT_LIMIT_LO] = limitCode;
    statWord[`STAT_STATE_HI:`STAT_STATE_LO] = phase;
    statWord[`STAT_NOK_HI:`STAT_NOK_LO] = nokCount;
  end

  always_comb begin
    next_ctrl = ctrl;
    next_prdata = 32'h0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (access) begin
      next_pready = 1'b1;
      next_pslverr = !(ctrlHit || statHit);
      if (pwrite && ctrlHit) begin
        next_ctrl = pwdata[15:0];
      end
      if (!pwrite && ctrlHit) begin
        next_prdata = {16'h0, ctrl};
      end
      if (!pwrite && statHit) begin
        next_prdata = statWord;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `CTRL_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  limit_t ceilCode;
  limit_t floorCode;
  logic [2:0] tmoCode;
  logic enable;
  logic [4:0] divMask;
  logic [1:0] divCode;
  logic [4:0] divCnt;
  logic [4:0] next_divCnt;
  logic sampleTick;
  logic [6:0] onCount;
  logic [6:0] next_onCount;
  logic timedOut;
  phase_t next_phase;
  logic [3:0] next_nokCount;
  logic next_outputGood;
  limit_t next_limitCode;
  limit_t rawLimit;

  assign ceilCode = ctrl[`CEIL_HI:`CEIL_LO];
  assign floorCode = ctrl[`FLOOR_HI:`FLOOR_LO];
  assign tmoCode = ctrl[`TMO_HI:`TMO_LO];
  assign enable = ctrl[`ENABLE_BIT];
  assign divCode = ctrl[`DIV_HI:`DIV_LO];
  // each code step opens the next higher bit above the base, so the mask stays a run of ones
  assign divMask = `DIV_BASE_MASK |
    {divCode == 2'h3, divCode >= 2'h2, divCode != 2'h0, 2'h0};
  assign sampleTick = (phase == IDLE) && enable && ((divCnt & divMask) == divMask);
  assign timedOut = (tmoCode != 3'h0) && (onCount >= timeoutCycles(tmoCode));

  always_comb begin
    next_divCnt = (phase == IDLE && enable) ? 5'(divCnt + 5'h1) : 5'h0;
    next_phase = phase;
    next_onCount = 7'(onCount + 7'h1);
    next_nokCount = nokCount;
    next_outputGood = outputGood;
    rawLimit = limitCode;
    case (phase)
      IDLE: begin
        next_onCount = 7'h0;
        if (sampleTick && outputLow) begin
          next_phase = CHARGE;
          rawLimit = (limitCode == 4'hf) ? limitCode : 4'(limitCode + 4'h1);
          next_nokCount = (nokCount == 4'hf) ? nokCount : 4'(nokCount + 4'h1);
          if (4'(nokCount + 4'h1) >= clearThreshold(ctrl[`CLRCNT_HI:`CLRCNT_LO])) begin
            next_outputGood = 1'b0;
          end
        end else if (sampleTick) begin
          next_nokCount = 4'h0;
          next_outputGood = 1'b1;
          rawLimit = (limitCode == 4'h0) ? limitCode : 4'(limitCode - 4'h1);
        end
      end
      CHARGE: begin
        if (peakReached || timedOut) begin
          next_phase = DISCHARGE;
          next_onCount = 7'h0;
          if (!peakReached) begin
            // the peak was never met, so a lower limit suits this load
            rawLimit = (limitCode == 4'h0) ? limitCode : 4'(limitCode - 4'h1);
          end
        end
      end
      DISCHARGE: begin
        if (zeroCurrent || timedOut) begin
          next_phase = IDLE;
          next_onCount = 7'h0;
        end
      end
      default: begin
        next_phase = IDLE;
        next_onCount = 7'h0;
      end
    endcase
    if (!enable) begin
      next_phase = IDLE;
      next_onCount = 7'h0;
      next_nokCount = 4'h0;
      next_outputGood = 1'b0;
    end
    next_limitCode = clampLimit(rawLimit, floorCode, ceilCode);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase <= IDLE;
      divCnt <= 5'h0;
      onCount <= 7'h0;
      nokCount <= 4'h0;
      outputGood <= 1'b0;
      limitCode <= `FLOOR_RESET;
      chargeSwitch <= 1'b0;
      dischargeSwitch <= 1'b0;
    end else begin
      phase <= next_phase;
      divCnt <= next_divCnt;
      onCount <= next_onCount;
      nokCount <= next_nokCount;
      outputGood <= next_outputGood;
      limitCode <= next_limitCode;
      chargeSwitch <= (next_phase == CHARGE);
      dischargeSwitch <= (next_phase == DISCHARGE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_ceilReset;
    @(posedge mclk) disable iff (1'b0)
    !resetn |=> ctrl[`CEIL_HI:`CEIL_LO] == `CEIL_RESET;
  endproperty
  a_ceilReset: assert property (p_ceilReset) else $error("ceiling reset code wrong");

  property p_floorWrite;
    (access && pwrite && ctrlHit) |=> floorCode == $past(pwdata[`FLOOR_HI:`FLOOR_LO]);
  endproperty
  a_floorWrite: assert property (p_floorWrite) else $error("floor write lost");

  property p_goodClear;
    $fell(outputGood) && $past(enable) |->
      $past(nokCount) + 4'h1 >= clearThreshold($past(ctrl[`CLRCNT_HI:`CLRCNT_LO]));
  endproperty
  a_goodClear: assert property (p_goodClear) else $error("good cleared too early");

  sequence s_chargeTimeout;
    phase == CHARGE && !peakReached && timedOut && enable;
  endsequence
  property p_timeout;
    s_chargeTimeout |=> phase == DISCHARGE ##0 dischargeSwitch && !chargeSwitch;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not end charge");

  property p_noTimeoutWhenOff;
    (phase == CHARGE && tmoCode == 3'h0 && !peakReached && enable) |=> phase == CHARGE;
  endproperty
  a_noTimeoutWhenOff: assert property (p_noTimeoutWhenOff)
    else $error("disabled timeout fired");

  sequence s_tick;
    sampleTick && $stable(ctrl);
  endsequence
  property p_tickSpacing;
    s_tick |=> !sampleTick [*3];
  endproperty
  a_tickSpacing: assert property (p_tickSpacing)
    else $error("idle sample faster than div 4");

  property p_disabledOff;
    !enable |=> !chargeSwitch && !dischargeSwitch && phase == IDLE;
  endproperty
  a_disabledOff: assert property (p_disabledOff) else $error("switch on while disabled");

  property p_limitRange;
    $past(floorCode) <= $past(ceilCode) && $stable(ctrl) |->
      limitCode >= floorCode && limitCode <= ceilCode;
  endproperty
  a_limitRange: assert property (p_limitRange)
    else $error("limit outside floor..ceiling");
endmodule // dcdc_hw_controller
`default_nettype wire

/* dcdc_power_stage.sv */
// behavioural inductor stage: current ramps to peak while charging, back to zero while discharging
`timescale 1ns/10ps
`default_nettype none
module dcdc_power_stage (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic chargeSwitch,
  input wire logic dischargeSwitch,
  input wire logic [7:0] rampCycles,
  output logic peakReachedRaw,
  output logic zeroCurrentRaw
);
  logic [7:0] rampCount, next_rampCount;
  logic lastCharge, next_lastCharge;
  always_comb begin
    next_lastCharge = chargeSwitch;
    next_rampCount = rampCount + 8'h01;
    // restart on every switch change so each phase is timed on its own
    if (chargeSwitch != lastCharge || !(chargeSwitch || dischargeSwitch)) begin
      next_rampCount = 8'h00;
    end else if (rampCount == 8'hff) begin
      next_rampCount = rampCount;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rampCount <= 8'h00;
      lastCharge <= 1'b0;
    end else begin
      rampCount <= next_rampCount;
      lastCharge <= next_lastCharge;
    end
  end
  // a ramp of ff never ends, so only the switch timeout can close the phase
  assign peakReachedRaw = chargeSwitch && rampCycles != 8'hff && rampCount >= rampCycles;
  assign zeroCurrentRaw = dischargeSwitch && rampCycles != 8'hff && rampCount >= rampCycles;
endmodule // dcdc_power_stage
`default_nettype wire

/* dcdc_hw_controller_bench.sv */
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "dcdc_params.svh"
module dcdc_hw_controller_bench;
  import dcdc_pkg::*;
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, outputLowRaw = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic pready, pslverr, e, peakReachedRaw, zeroCurrentRaw;
  logic chargeSwitch, dischargeSwitch, outputGood;
  logic [7:0] rampCycles = 8'h03;
  limit_t limitCode;
  int mismatches = 0, compares = 0, n, m, p[8];
  always #10 mclk = ~mclk;
  dcdc_hw_controller i_dut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .outputLowRaw, .peakReachedRaw, .zeroCurrentRaw,
    .chargeSwitch, .dischargeSwitch, .limitCode, .outputGood);
  dcdc_power_stage i_stage (.mclk, .resetn, .chargeSwitch, .dischargeSwitch, .rampCycles,
    .peakReachedRaw, .zeroCurrentRaw);
  function automatic logic [31:0] cf(input logic [3:0] ce, input logic [3:0] fl,
    input logic [1:0] cc, input logic [2:0] tm, input logic [1:0] dv, input logic en);
    return {16'h0000, ce, fl, cc, tm, dv, en};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  // a fresh edge first, so release and the next setup never share a time step
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      $display("Error at %0t: no pready from the register bus", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rise;
    n = 0;
    while (chargeSwitch !== 1'b0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    while (chargeSwitch !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      $display("Error at %0t: charge switch never rose", $time);
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    close_out;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    apb(1'b0, `CTRL_ADDR, 32'h0);
    chk(r, 32'h0000_84a2);
    chk(limitCode, 32'h4);
    apb(1'b1, `STAT_ADDR, 32'hffff_ffff);
    apb(1'b0, `STAT_ADDR, 32'h0);
    chk(r, 32'h0000_0140);
    apb(1'b0, 32'h5000_0088, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, `CTRL_ADDR, 32'h1234_abcc);
    apb(1'b0, `CTRL_ADDR, 32'h0);
    chk(r, 32'h0000_abcc);
    chk({chargeSwitch, dischargeSwitch, outputGood}, 32'h0);
    outputLowRaw <= 1'b1;
    // the differences between periods cancel the synchroniser latency
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, `CTRL_ADDR, cf(4'hf, 4'h0, 2'h0, 3'h0, d[1:0], 1'b1));
      rise;
      rise;
      rise;
      p[d] = n;
      chk(p[d] - p[0], (4 << d) - 4);
    end
    rampCycles <= 8'hff;
    for (int c = 1; c < 8; c++) begin
      apb(1'b1, `CTRL_ADDR, cf(4'hf, 4'h0, 2'h0, c[2:0], 2'h0, 1'b1));
      rise;
      rise;
      n = 0;
      while (chargeSwitch === 1'b1 && n < 3000) begin
        @(posedge mclk);
        n++;
      end
      p[c] = n;
      chk(p[c] - p[1], (c * 25) / 2 - 12);
      chk(p[c] * `CLK_PERIOD_NS > c * `TMO_STEP_NS, 32'h1);
    end
    rampCycles <= 8'd100;
    apb(1'b1, `CTRL_ADDR, cf(4'hf, 4'h0, 2'h0, 3'h0, 2'h0, 1'b1));
    rise;
    rise;
    n = 0;
    while (chargeSwitch === 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk(n >= 100, 32'h1);
    rampCycles <= 8'h03;
    apb(1'b1, `CTRL_ADDR, cf(4'hf, 4'h2, 2'h0, 3'h0, 2'h0, 1'b1));
    repeat (600) @(posedge mclk);
    chk(limitCode, 32'hf);
    apb(1'b1, `CTRL_ADDR, cf(4'h6, 4'h2, 2'h0, 3'h0, 2'h0, 1'b1));
    repeat (2) @(posedge mclk);
    chk(limitCode, 32'h6);
    outputLowRaw <= 1'b0;
    repeat (600) @(posedge mclk);
    chk(limitCode, 32'h2);
    chk(outputGood, 32'h1);
    for (int k = 0; k < 4; k++) begin
      outputLowRaw <= 1'b0;
      apb(1'b1, `CTRL_ADDR, cf(4'hf, 4'h0, k[1:0], 3'h0, 2'h0, 1'b1));
      repeat (200) @(posedge mclk);
      outputLowRaw <= 1'b1;
      m = 0;
      do begin
        rise;
        @(posedge mclk);
        m++;
      end while (outputGood === 1'b1 && m < 20);
      chk(m, k == 3 ? 15 : 2 << k);
    end
    apb(1'b1, `CTRL_ADDR, cf(4'hf, 4'h0, 2'h2, 3'h4, 2'h1, 1'b0));
    repeat (100) @(posedge mclk);
    chk({chargeSwitch, dischargeSwitch, outputGood}, 32'h0);
    apb(1'b0, `STAT_ADDR, 32'h0);
    chk(r & 32'h0000_f701, 32'h0000_0100);
    close_out;
  end
endmodule // dcdc_hw_controller_bench
`default_nettype wire
